// ### rtl/ptb_consts.svh
// offsets, field positions, reset values and timing counts of the pattern test block
`ifndef PTB_CONSTS_SVH
`define PTB_CONSTS_SVH
`define PTB_ADDR_W          4
`define PTB_REG_CSR         4'h0
`define PTB_REG_SWITCH      4'h1
`define PTB_REG_IRQ_STAT    4'h2
`define PTB_REG_IRQ_MASK    4'h3
`define PTB_BIT_TYPE        7
`define PTB_BIT_ERRINS      6
`define PTB_BIT_INV         5
`define PTB_BIT_LOCK        4
`define PTB_BIT_DET_EN      3
`define PTB_BIT_GEN_EN      2
`define PTB_BIT_RX_BYP      1
`define PTB_BIT_TX_BYP      0
`define PTB_BIT_SWITCH      3
`define PTB_IRQ_LOCK_GAIN   0
`define PTB_IRQ_LOCK_LOSS   1
`define PTB_CSR_RESET       8'h00
`define PTB_LOCK_RUN        6'h23
`define PTB_ERR_LIMIT       4'h8
`define PTB_ERR_WINDOW      8'hFF
`define PTB_UNMAPPED_DATA   32'h00000000
`endif

// ### rtl/ptb_pattern_gen.sv
// prbs15 / quasi-random pattern source with single error insertion and invert
module ptb_pattern_gen (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  // control
  input  wire logic run,
  input  wire logic qrts,
  input  wire logic invert,
  input  wire logic err_pulse,
  // pattern out
  output logic      bit_ff
);
  logic [14:0] lfsr_ff;
  logic        fb;

  // qrts: prbs15 with zero runs limited to 14 by forcing a one on the output
  assign fb = lfsr_ff[14] ^ lfsr_ff[13];

  // shift the polynomial x^15+x^14+1 while running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lfsr_ff <= 15'h7FFF;
    end else if (ce && run) begin
      lfsr_ff <= {lfsr_ff[13:0], fb};
    end
  end

  // output bit with qrts zero suppression, inversion and error
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_ff <= 1'b0;
    end else if (ce) begin
      bit_ff <= run ? (((qrts && lfsr_ff[13:0] == 14'h0000) ? 1'b1 : fb) ^ invert ^ err_pulse) : 1'b0;
    end
  end
endmodule : ptb_pattern_gen

// ### rtl/ptb_pattern_test.sv
// per-channel prbs/qrts test pattern control with framer bypass and avalon-mm registers
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`include "ptb_consts.svh"

// Behaviour
// - lock status bit reads 1 once the active detector has locked, else 0.
// - lock status follows the receive detector with switch off, transmit detector with switch on.
// - the switch setting lives in bit 3 of its own control register.
// - switch off and detect enabled, the receive side checks line input for the pattern.
// - switch on and detect enabled, the transmit side checks backplane data for the pattern.
// - detection runs only while the detect enable bit is 1, reset 0.
// - switch off and generate enabled, the transmit side sends the pattern to the line.
// - switch on and generate enabled, the receive side sends the pattern to the backplane.
// - the generator runs only while the generate enable bit is 1, reset 0.
// - receive framer is bypassed while its bypass bit is 1, reset 0.
// - transmit framer is bypassed while its bypass bit is 1, reset 0.
// - pattern type 0 selects prbs15 x^15+x^14+1, 1 selects the quasi-random signal.
// - each 0-to-1 write of error insert flips exactly one generated bit.
// - error insertion is ignored while generation is off.
// - data invert flips generated output and detector input.
module ptb_pattern_test
  import ptb_pkg::*;
(
  // clock, enable, reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   ce,
  // avalon-mm slave
  input  wire logic [`PTB_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // interrupt
  output logic                        irq,
  // line side
  input  wire logic                   line_rx_bit,
  output logic                        line_tx_bit,
  // backplane side
  input  wire logic                   bp_tx_bit,
  output logic                        bp_rx_bit,
  // framer paths (normal framed data)
  input  wire logic                   framed_tx_bit,
  input  wire logic                   framed_rx_bit,
  output logic                        tx_framer_bypass,
  output logic                        rx_framer_bypass
);
  import ptb_pkg::*;

  ptb_byte_t   csr_ff;
  logic        switch_ff;
  logic [1:0]  irq_stat_ff;
  logic [1:0]  irq_mask_ff;
  logic        ack_ff;
  logic        err_req_ff;
  logic        err_pulse;
  logic        gen_bit;
  logic        det_in;
  logic        pred;
  logic [14:0] det_sr_ff;
  logic [5:0]  run_cnt_ff;
  logic [3:0]  err_cnt_ff;
  logic [7:0]  win_cnt_ff;
  logic        lock_ff;
  logic        lock_d_ff;
  ptb_det_e    det_st_ff;
  ptb_det_e    nxt_det_st;
  logic        wr_csr;
  logic        gen_on;
  logic        det_on;
  logic        access;

  // true when a write lands on a given register with its low byte enabled
  function automatic logic wr_hit(input logic [`PTB_ADDR_W-1:0] a, input logic [`PTB_ADDR_W-1:0] r,
                                  input logic w, input logic [3:0] be);
    wr_hit = w && be[0] && (a == r);
  endfunction : wr_hit

  // writes land only at the edge where waitrequest is seen low
  assign access = (avs_read || avs_write) && ack_ff && ce;
  assign wr_csr = access && wr_hit(avs_address, `PTB_REG_CSR, avs_write, avs_byteenable);
  assign gen_on = csr_ff[`PTB_BIT_GEN_EN];
  assign det_on = csr_ff[`PTB_BIT_DET_EN];

  // bus handshake: one wait cycle, then waitrequest low for one edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
    end else if (ce) begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
    end
  end

  // control register: writable bits; lock bit is read only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csr_ff <= `PTB_CSR_RESET;
    end else if (wr_csr) begin
      csr_ff <= avs_writedata[7:0] & ~(8'h01 << `PTB_BIT_LOCK);
    end
  end

  // switch function control register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      switch_ff <= 1'b0;
    end else if (access && wr_hit(avs_address, `PTB_REG_SWITCH, avs_write, avs_byteenable)) begin
      switch_ff <= avs_writedata[`PTB_BIT_SWITCH];
    end
  end

  // error insert request: rising edge of the written bit, only while generating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_req_ff <= 1'b0;
    end else if (ce) begin
      if (wr_csr && avs_writedata[`PTB_BIT_ERRINS] && !csr_ff[`PTB_BIT_ERRINS] && gen_on) begin
        err_req_ff <= 1'b1;
      end else begin
        err_req_ff <= 1'b0;
      end
    end
  end
  assign err_pulse = err_req_ff && gen_on;

  ptb_pattern_gen u_gen (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .run       (gen_on),
    .qrts      (csr_ff[`PTB_BIT_TYPE]),
    .invert    (csr_ff[`PTB_BIT_INV]),
    .err_pulse (err_pulse),
    .bit_ff    (gen_bit)
  );

  // data path steering: generated bit replaces the chosen output, bypass passes payload raw
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_tx_bit <= 1'b0;
      bp_rx_bit   <= 1'b0;
    end else if (ce) begin
      if (gen_on && !switch_ff) begin
        line_tx_bit <= gen_bit;
      end else begin
        line_tx_bit <= csr_ff[`PTB_BIT_TX_BYP] ? bp_tx_bit : framed_tx_bit;
      end
      if (gen_on && switch_ff) begin
        bp_rx_bit <= gen_bit;
      end else begin
        bp_rx_bit <= csr_ff[`PTB_BIT_RX_BYP] ? line_rx_bit : framed_rx_bit;
      end
    end
  end

  // bypass flags to the framers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_framer_bypass <= 1'b0;
      rx_framer_bypass <= 1'b0;
    end else if (ce) begin
      tx_framer_bypass <= csr_ff[`PTB_BIT_TX_BYP];
      rx_framer_bypass <= csr_ff[`PTB_BIT_RX_BYP];
    end
  end

  // detector input: line side normally, transmit backplane with switch on
  assign det_in = (switch_ff ? bp_tx_bit : line_rx_bit) ^ csr_ff[`PTB_BIT_INV];
  assign pred   = (csr_ff[`PTB_BIT_TYPE] && det_sr_ff[13:0] == 14'h0000) ? 1'b1
                : (det_sr_ff[14] ^ det_sr_ff[13]);

  // self-synchronising predictor: history of received bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      det_sr_ff <= 15'h0000;
    end else if (ce && det_on) begin
      det_sr_ff <= {det_sr_ff[13:0], det_in};
    end
  end

  // detector state machine
  always_comb begin
    nxt_det_st = det_st_ff;
    case (det_st_ff)
      PTB_ST_IDLE: begin
        if (det_on) begin
          nxt_det_st = PTB_ST_SEARCH;
        end
      end
      PTB_ST_SEARCH: begin
        if (!det_on) begin
          nxt_det_st = PTB_ST_IDLE;
        end else if (run_cnt_ff == `PTB_LOCK_RUN) begin
          nxt_det_st = PTB_ST_LOCKED;
        end
      end
      PTB_ST_LOCKED: begin
        if (!det_on) begin
          nxt_det_st = PTB_ST_IDLE;
        end else if (err_cnt_ff == `PTB_ERR_LIMIT) begin
          nxt_det_st = PTB_ST_SEARCH;
        end
      end
      default: begin
        nxt_det_st = PTB_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      det_st_ff <= PTB_ST_IDLE;
    end else if (ce) begin
      det_st_ff <= nxt_det_st;
    end
  end

  // run of consecutive matches while searching
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_cnt_ff <= 6'h00;
    end else if (ce) begin
      if (det_st_ff != PTB_ST_SEARCH || det_in != pred) begin
        run_cnt_ff <= 6'h00;
      end else if (run_cnt_ff != `PTB_LOCK_RUN) begin
        run_cnt_ff <= run_cnt_ff + 6'h01;
      end
    end
  end

  // errors within a window while locked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      win_cnt_ff <= 8'h00;
      err_cnt_ff <= 4'h0;
    end else if (ce) begin
      if (det_st_ff != PTB_ST_LOCKED || win_cnt_ff == `PTB_ERR_WINDOW) begin
        win_cnt_ff <= 8'h00;
        err_cnt_ff <= 4'h0;
      end else begin
        win_cnt_ff <= win_cnt_ff + 8'h01;
        if (det_in != pred && err_cnt_ff != `PTB_ERR_LIMIT) begin
          err_cnt_ff <= err_cnt_ff + 4'h1;
        end
      end
    end
  end

  // lock flag and its previous value for events
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_ff   <= 1'b0;
      lock_d_ff <= 1'b0;
    end else if (ce) begin
      lock_ff   <= (det_st_ff == PTB_ST_LOCKED) && det_on;
      lock_d_ff <= lock_ff;
    end
  end

  // sticky events, set wins over write-one-to-clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_ff <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `PTB_IRQ_LOCK_GAIN) ? (lock_ff && !lock_d_ff) : (!lock_ff && lock_d_ff)) begin
          irq_stat_ff[i] <= 1'b1;
        end else if (access && wr_hit(avs_address, `PTB_REG_IRQ_STAT, avs_write, avs_byteenable)
                     && avs_writedata[i]) begin
          irq_stat_ff[i] <= 1'b0;
        end
      end
    end
  end

  // interrupt mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_ff <= 2'h0;
    end else if (access && wr_hit(avs_address, `PTB_REG_IRQ_MASK, avs_write, avs_byteenable)) begin
      irq_mask_ff <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // read data, latched as the request is first seen so they stand while waitrequest is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h00000000;
    end else if (ce && avs_read && !ack_ff) begin
      case (avs_address)
        `PTB_REG_CSR:      avs_readdata <= {24'h000000, csr_ff | ({7'h00, lock_ff} << `PTB_BIT_LOCK)};
        `PTB_REG_SWITCH:   avs_readdata <= {28'h0000000, switch_ff, 3'h0};
        `PTB_REG_IRQ_STAT: avs_readdata <= {30'h00000000, irq_stat_ff};
        `PTB_REG_IRQ_MASK: avs_readdata <= {30'h00000000, irq_mask_ff};
        default:           avs_readdata <= `PTB_UNMAPPED_DATA;
      endcase
    end
  end
endmodule : ptb_pattern_test

// ### rtl/ptb_pkg.sv
// types of the pattern test block
package ptb_pkg;
  typedef logic [7:0] ptb_byte_t;
  typedef enum logic [2:0] {
    PTB_ST_IDLE   = 3'b001,
    PTB_ST_SEARCH = 3'b010,
    PTB_ST_LOCKED = 3'b100
  } ptb_det_e;
endpackage : ptb_pkg

// ### sim/ptb_far_end.sv
// far end model: loops line and backplane streams back, or cuts them
module ptb_far_end (
  // clock
  input wire logic clk,
  // loop cuts
  input wire logic cut_line,
  input wire logic cut_bp,
  // device side
  input wire logic line_tx_bit,
  input wire logic bp_rx_bit,
  output logic     line_rx_bit,
  output logic     bp_tx_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog = 1'b0;
  // one bit of delay; a cut path toggles so no stale value lingers
  always @(posedge clk) begin
    tog         <= ~tog;
    line_rx_bit <= cut_line ? tog : line_tx_bit;
    bp_tx_bit   <= cut_bp ? tog : bp_rx_bit;
  end
endmodule : ptb_far_end

// ### sim/ptb_pattern_test_asserts.sv
// port checker of the pattern test block and its bind
`include "ptb_consts.svh"
module ptb_pattern_test_asserts (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rstn,
  // register bus
  input wire logic [`PTB_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  // line stream and bypass levels
  input wire logic                   line_tx_bit,
  input wire logic                   tx_framer_bypass,
  input wire logic                   rx_framer_bypass
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        done;
  logic        wr;
  logic        rd_csr;
  logic [7:0]  csr_ff;
  logic [7:0]  sw_ff;
  logic [5:0]  quiet_ff;
  logic [14:0] hist_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // completed transfers
  assign done   = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr     = done & avs_write & avs_byteenable[0];
  assign rd_csr = done & avs_read & (avs_address == `PTB_REG_CSR);
  // shadow of written controls, cycles since last write, line history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csr_ff   <= 8'h00;
      sw_ff    <= 8'h00;
      quiet_ff <= 6'h00;
      hist_ff  <= 15'h0000;
    end else begin
      if (wr && avs_address == `PTB_REG_CSR) csr_ff <= avs_writedata[7:0];
      if (wr && avs_address == `PTB_REG_SWITCH) sw_ff <= avs_writedata[7:0];
      quiet_ff <= wr ? 6'h00 : quiet_ff + {5'h00, quiet_ff != 6'h3F};
      hist_ff  <= {hist_ff[13:0], line_tx_bit};
    end
  end
  a_wait_bound: assert property ((avs_read | avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("bus request not answered in time");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_upper_zero: assert property (done && avs_read |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_lock_needs_det: assert property (rd_csr && avs_readdata[4] |-> avs_readdata[3])
    else $error("lock reported with detection off");
  a_csr_readback: assert property (rd_csr |-> {avs_readdata[7:5], avs_readdata[3:0]} == {csr_ff[7:5], csr_ff[3:0]})
    else $error("control bits read back wrong");
  a_switch_readback: assert property (done && avs_read && avs_address == `PTB_REG_SWITCH |-> avs_readdata[3] == sw_ff[3])
    else $error("switch bit read back wrong");
  a_rx_bypass: assert property (quiet_ff > 6'h02 |-> rx_framer_bypass == csr_ff[1])
    else $error("receive bypass level wrong");
  a_tx_bypass: assert property (quiet_ff > 6'h02 |-> tx_framer_bypass == csr_ff[0])
    else $error("transmit bypass level wrong");
  a_gen_prbs: assert property (quiet_ff == 6'h3F && csr_ff[2] && !csr_ff[7] && !sw_ff[3] |-> line_tx_bit == (hist_ff[13] ^ hist_ff[14] ^ csr_ff[5]))
    else $error("line output breaks the pattern recurrence");
endmodule : ptb_pattern_test_asserts

bind ptb_pattern_test ptb_pattern_test_asserts u_asserts (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .line_tx_bit, .tx_framer_bypass, .rx_framer_bypass);

// ### sim/ptb_pattern_test_bench.sv
// self-checking bench of the pattern test block
`include "ptb_consts.svh"
module ptb_pattern_test_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq, line_rx_bit, line_tx_bit, bp_tx_bit, bp_rx_bit, tx_framer_bypass, rx_framer_bypass;
  logic        cut_line = 1'b1;
  logic        cut_bp = 1'b1;
  logic        ce = 1'b1;
  logic        framed = 1'b1;
  logic        mon_en = 1'b0;
  logic [14:0] h = 15'h0;
  logic [31:0] q;
  int          err_total = 0;
  int          compares = 0;
  int          viol = 0;
  always #5 clk = ~clk;
  ptb_pattern_test dut (.clk, .rstn, .ce(ce), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .irq, .line_rx_bit, .line_tx_bit, .bp_tx_bit,
    .bp_rx_bit, .framed_tx_bit(framed), .framed_rx_bit(framed), .tx_framer_bypass, .rx_framer_bypass);
  ptb_far_end u_far (.clk, .cut_line, .cut_bp, .line_tx_bit, .bp_rx_bit, .line_rx_bit, .bp_tx_bit);
  // counts line bits that break the prbs15 recurrence
  always @(negedge clk) begin
    if (mon_en && line_tx_bit !== (h[13] ^ h[14])) viol++;
    h <= {h[13:0], line_tx_bit};
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      results();
    end
    @(posedge clk);
  endtask : bus
  task automatic wait_lock(input logic want);
    int n;
    n = 0;
    do begin
      bus(1'b0, `PTB_REG_CSR, 32'h0);
      n++;
    end while (q[4] !== want && n < 60);
    chk(q[4], want);
    if (q[4] !== want) results();
  endtask : wait_lock
  task automatic t_reset;
    bus(1'b0, `PTB_REG_CSR, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `PTB_REG_SWITCH, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 4'hB, 32'h0);
    chk(q, 32'h0);
    chk(irq, 1'b0);
  endtask : t_reset
  task automatic t_bypass;
    logic p, r;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `PTB_REG_CSR, i);
      bus(1'b0, `PTB_REG_CSR, 32'h0);
      chk(q, i);
      chk({rx_framer_bypass, tx_framer_bypass}, i);
      // bypassed paths repeat the far side one bit later, framed paths show the framer bit
      @(negedge clk);
      p = bp_tx_bit;
      r = line_rx_bit;
      @(negedge clk);
      chk(line_tx_bit, i[0] ? p : framed);
      chk(bp_rx_bit, i[1] ? r : framed);
    end
    // clock enable low freezes the bypassed line output while the far side toggles
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    p = line_tx_bit;
    repeat (4) begin
      @(negedge clk);
      chk(line_tx_bit, p);
    end
    @(posedge clk);
    ce <= 1'b1;
    bus(1'b1, `PTB_REG_CSR, 32'h0);
  endtask : t_bypass
  task automatic t_lock_irq;
    cut_line <= 1'b0;
    bus(1'b1, `PTB_REG_IRQ_MASK, 32'h1);
    bus(1'b1, `PTB_REG_CSR, 32'hC);
    bus(1'b0, `PTB_REG_CSR, 32'h0);
    chk(q[4], 1'b0);
    repeat (18) @(posedge clk);
    viol = 0;
    mon_en <= 1'b1;
    wait_lock(1'b1);
    chk(viol, 0);
    mon_en <= 1'b0;
    chk(irq, 1'b1);
    bus(1'b0, `PTB_REG_IRQ_STAT, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, `PTB_REG_IRQ_STAT, 32'h1);
    bus(1'b0, `PTB_REG_IRQ_STAT, 32'h0);
    chk(q, 32'h0);
    chk(irq, 1'b0);
    cut_line <= 1'b1;
    wait_lock(1'b0);
    bus(1'b0, `PTB_REG_IRQ_STAT, 32'h0);
    chk(q, 32'h2);
    chk(irq, 1'b0);
    bus(1'b1, `PTB_REG_IRQ_STAT, 32'h2);
    bus(1'b1, `PTB_REG_CSR, 32'h0);
  endtask : t_lock_irq
  task automatic t_err;
    bus(1'b1, `PTB_REG_CSR, 32'h4);
    repeat (20) @(posedge clk);
    viol = 0;
    mon_en <= 1'b1;
    bus(1'b1, `PTB_REG_CSR, 32'h44);
    repeat (40) @(posedge clk);
    chk(viol, 3);
    mon_en <= 1'b0;
    bus(1'b1, `PTB_REG_CSR, 32'h0);
    bus(1'b1, `PTB_REG_CSR, 32'h40);
    bus(1'b1, `PTB_REG_CSR, 32'h44);
    repeat (18) @(posedge clk);
    viol = 0;
    mon_en <= 1'b1;
    repeat (40) @(posedge clk);
    chk(viol, 0);
    mon_en <= 1'b0;
    bus(1'b1, `PTB_REG_CSR, 32'h0);
  endtask : t_err
  task automatic t_switch;
    bus(1'b1, `PTB_REG_SWITCH, 32'h8);
    bus(1'b0, `PTB_REG_SWITCH, 32'h0);
    chk(q[3], 1'b1);
    cut_bp <= 1'b0;
    bus(1'b1, `PTB_REG_CSR, 32'hC);
    wait_lock(1'b1);
    cut_line <= 1'b0;
    cut_bp   <= 1'b1;
    wait_lock(1'b0);
    bus(1'b1, `PTB_REG_CSR, 32'h0);
    bus(1'b1, `PTB_REG_SWITCH, 32'h0);
  endtask : t_switch
  task automatic t_types;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `PTB_REG_CSR, {24'h0, i[1], 1'b0, i[0], 5'h0C});
      wait_lock(1'b1);
      bus(1'b1, `PTB_REG_CSR, 32'h0);
      wait_lock(1'b0);
    end
  endtask : t_types
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    $display("reset test done");
    t_bypass();
    $display("bypass test done");
    t_lock_irq();
    $display("lock and interrupt test done");
    t_err();
    $display("error insert test done");
    t_switch();
    $display("switch test done");
    t_types();
    $display("type and invert test done");
    results();
  end
endmodule : ptb_pattern_test_bench
